// >>> include/flash_status_regs.vh
/*
 * Constants for the status word and write-enable latch block of a serial
 * NOR flash: status bit positions, reset values, opcodes and timing counts.
 * Assumes it is included by bare name from design files under core/.
 */
`ifndef FLASH_STATUS_REGS_VH
`define FLASH_STATUS_REGS_VH

// ****************************************************************
// Status word layout and reset values
// ****************************************************************
`define FSW_BIT_BUSY 0
`define FSW_BIT_LATCH 1
`define FSW_BIT_BP_LO 2
`define FSW_BIT_BP_HI 5
`define FSW_BIT_QUAD 6
`define FSW_BIT_LOCK 7
`define FSW_STATUS_RESET 8'h00
`define FSW_NV_RESET 6'h00
`define FSW_FUNC_READ_VALUE 8'h00

// ****************************************************************
// Opcodes
// ****************************************************************
`define FSW_OP_WSET 8'h06
`define FSW_OP_WCLR 8'h04
`define FSW_OP_RDSR 8'h05
`define FSW_OP_RDFR 8'h48
`define FSW_OP_STWR 8'h01
`define FSW_OP_FNWR 8'h42
`define FSW_OP_RST_EN 8'h66
`define FSW_OP_RST 8'h99
`define FSW_OP_SUSPEND 8'h75
`define FSW_OP_RESUME 8'h7A
`define FSW_OP_PG 8'h02
`define FSW_OP_PP4 8'h12
`define FSW_OP_PGQ_A 8'h32
`define FSW_OP_PGQ_B 8'h38
`define FSW_OP_PPQ4_A 8'h34
`define FSW_OP_PPQ4_B 8'h3E
`define FSW_OP_SE_A 8'hD7
`define FSW_OP_SE_B 8'h20
`define FSW_OP_SE4 8'h21
`define FSW_OP_BE32 8'h52
`define FSW_OP_BE32_4 8'h5C
`define FSW_OP_BE64 8'hD8
`define FSW_OP_BE64_4 8'hDC
`define FSW_OP_CE_A 8'hC7
`define FSW_OP_CE_B 8'h60
`define FSW_OP_RDPAR_NV 8'h65
`define FSW_OP_RDPAR_V 8'h63
`define FSW_OP_XRDPAR_NV 8'h85
`define FSW_OP_XRDPAR_V 8'h83
`define FSW_OP_INFO_ERASE 8'h64
`define FSW_OP_INFO_PROG 8'h62
`define FSW_OP_BOOT_WRITE 8'h15
`define FSW_OP_BANK_NV 8'h18
`define FSW_OP_BANK_V 8'hC5
`define FSW_OP_DYB 8'hFB
`define FSW_OP_DYB4 8'hE1
`define FSW_OP_PPB 8'hFD
`define FSW_OP_PPB4 8'hE3
`define FSW_OP_PPB_ERASE 8'hE4
`define FSW_OP_ASP_PROG 8'h2F
`define FSW_OP_PPB_LOCK 8'hA6
`define FSW_OP_FREEZE 8'h91
`define FSW_OP_GANG_LOCK 8'h7E
`define FSW_OP_GANG_UNLOCK 8'h98
`define FSW_OP_PASSWORD 8'hE8
`define FSW_OP_DLP_NV 8'h43
`define FSW_OP_DLP_V 8'h4A
`define FSW_OP_VOL_READ_PARAMS 8'hC0
`define FSW_OP_VOL_BANK_WRITE 8'h17

// ****************************************************************
// Operation classes and timing counts in core clock cycles
// ****************************************************************
`define FSW_CLASS_NONE 2'd0
`define FSW_CLASS_PROG 2'd1
`define FSW_CLASS_ERASE 2'd2
`define FSW_CLASS_REG 2'd3
`define FSW_PROG_CYCLES 24'h00_0400
`define FSW_ERASE_CYCLES 24'h00_4000
`define FSW_CHIP_ERASE_CYCLES 24'h01_0000
`define FSW_REG_WRITE_CYCLES 24'h00_0200
`define FSW_CNT_SAT 6'h3F

`endif

// >>> core/pin_sync.v
/*
 * Two-flop synchroniser for a group of pins.
 * Assumes the inputs are asynchronous to clk_i; only stage two is read.
 */
`timescale 1ns/10ps
module pin_sync #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire clk_i,
    input wire rstn_i,
    // Pins in, synchronised out
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] stage1_q;

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            stage1_q <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else begin
            stage1_q <= async_i;
            sync_o <= stage1_q;
        end
    end
endmodule // pin_sync

// >>> core/op_busy_timer.v
/*
 * Down counter that models the duration of an internal operation.
 * Assumes start_i is a one-cycle pulse; hold_i freezes the count.
 */
`timescale 1ns/10ps
module op_busy_timer #(
    parameter CW = 24
) (
    // Clock and reset
    input wire clk_i,
    input wire rstn_i,
    // Control
    input wire start_i,
    input wire [CW-1:0] len_i,
    input wire hold_i,
    input wire abort_i,
    // Status
    output reg busy_o,
    output reg done_o
);
    reg [CW-1:0] left_q;

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            left_q <= {CW{1'b0}};
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (abort_i) begin
                busy_o <= 1'b0;
                left_q <= {CW{1'b0}};
            end else if (start_i && !busy_o) begin
                busy_o <= 1'b1;
                left_q <= len_i;
            end else if (busy_o && !hold_i) begin
                if (left_q <= {{(CW-1){1'b0}}, 1'b1}) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                    left_q <= {CW{1'b0}};
                end else begin
                    left_q <= left_q - {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // op_busy_timer

// >>> core/flash_status_write_latch.v
/*
 * Status word and write-enable latch of a serial NOR flash, with the serial
 * front end that reads the status word and admits or refuses instructions.
 * Assumes the host drives chip select, serial clock and data in mode 0 at a
 * rate well below a quarter of core_clk_i; all pins are synchronised here.
 */
// Notes on behaviour
// - Register reads repeat until chip select rises.
// - Status word layout; every bit resets to zero.
// - Busy flag is read-only, volatile, shows activity.
// - Busy set through program, erase, register writes.
// - While busy only reads, resets and suspend accepted.
// - Suspend accepted during program or erase.
// - Busy clears on completion regardless of outcome.
// - Latch zero refuses the latch-required instructions.
// - Write-disable opcode clears the latch.
// - Latch clears after program, erase, register write, except gang lock and unlock; here untimed volatile writes (63, 83, C5, FB, E1, 91, 4A) leave it set.
// - Status write data never changes the latch bit.
// - Protect, quad, lockout bits written by status write.
// - Block-protect ones mark blocks write-protected.
// - Quad-enable bit turns on four-line data.
// - Lockout bit marks status word write-protected.
// - Page programs need the latch set.
// - Sector, block and chip erases need latch.
// - Status, function, read-parameter writes need latch.
// - Info-row, autoboot, bank writes need latch.
// - Data learning pattern writes need latch.
// - Volatile read-parameter and bank writes skip latch.
// - Lockout with protect pin low ignores status write.
// - Chip erase ignored unless protect bits zero.
`timescale 1ns/10ps
`include "flash_status_regs.vh"
module flash_status_write_latch #(
    parameter [23:0] PROG_CYCLES = `FSW_PROG_CYCLES,
    parameter [23:0] ERASE_CYCLES = `FSW_ERASE_CYCLES,
    parameter [23:0] CHIP_ERASE_CYCLES = `FSW_CHIP_ERASE_CYCLES,
    parameter [23:0] REG_WRITE_CYCLES = `FSW_REG_WRITE_CYCLES
) (
    // Clock and reset
    input wire core_clk_i,
    input wire rstn_i,
    // Serial pins
    input wire cs_n_i,
    input wire sclk_i,
    input wire si_i,
    input wire wp_n_i,
    output reg so_o,
    output reg so_oe_n_o,
    // Status view
    output reg [7:0] status_word_o,
    output reg quad_lines_enable_o,
    output reg [3:0] block_protect_o,
    // Operation hand-off to the array
    output reg op_start_o,
    output reg [7:0] op_code_o,
    output reg op_done_o
);

    // ****************************************************************
    // Opcode decoding
    // ****************************************************************
    function latch_needed;
        input [7:0] op;
        begin
            case (op)
                `FSW_OP_PG, `FSW_OP_PP4, `FSW_OP_PGQ_A, `FSW_OP_PGQ_B,
                `FSW_OP_PPQ4_A, `FSW_OP_PPQ4_B: latch_needed = 1'b1;
                `FSW_OP_SE_A, `FSW_OP_SE_B, `FSW_OP_SE4, `FSW_OP_BE32,
                `FSW_OP_BE32_4, `FSW_OP_BE64, `FSW_OP_BE64_4,
                `FSW_OP_CE_A, `FSW_OP_CE_B: latch_needed = 1'b1;
                `FSW_OP_STWR, `FSW_OP_FNWR, `FSW_OP_RDPAR_NV, `FSW_OP_RDPAR_V,
                `FSW_OP_XRDPAR_NV, `FSW_OP_XRDPAR_V: latch_needed = 1'b1;
                `FSW_OP_INFO_ERASE, `FSW_OP_INFO_PROG, `FSW_OP_BOOT_WRITE,
                `FSW_OP_BANK_NV, `FSW_OP_BANK_V: latch_needed = 1'b1;
                `FSW_OP_DYB, `FSW_OP_DYB4, `FSW_OP_PPB, `FSW_OP_PPB4,
                `FSW_OP_PPB_ERASE, `FSW_OP_ASP_PROG, `FSW_OP_PPB_LOCK,
                `FSW_OP_FREEZE, `FSW_OP_GANG_LOCK, `FSW_OP_GANG_UNLOCK,
                `FSW_OP_PASSWORD: latch_needed = 1'b1;
                `FSW_OP_DLP_NV, `FSW_OP_DLP_V: latch_needed = 1'b1;
                // Volatile read-parameter and bank writes fall through here.
                default: latch_needed = 1'b0;
            endcase
        end
    endfunction

    function [1:0] op_class;
        input [7:0] op;
        begin
            case (op)
                `FSW_OP_PG, `FSW_OP_PP4, `FSW_OP_PGQ_A, `FSW_OP_PGQ_B,
                `FSW_OP_PPQ4_A, `FSW_OP_PPQ4_B, `FSW_OP_INFO_PROG,
                `FSW_OP_DLP_NV: op_class = `FSW_CLASS_PROG;
                `FSW_OP_SE_A, `FSW_OP_SE_B, `FSW_OP_SE4, `FSW_OP_BE32,
                `FSW_OP_BE32_4, `FSW_OP_BE64, `FSW_OP_BE64_4, `FSW_OP_CE_A,
                `FSW_OP_CE_B, `FSW_OP_INFO_ERASE,
                `FSW_OP_PPB_ERASE: op_class = `FSW_CLASS_ERASE;
                `FSW_OP_STWR, `FSW_OP_FNWR, `FSW_OP_RDPAR_NV, `FSW_OP_XRDPAR_NV,
                `FSW_OP_BOOT_WRITE, `FSW_OP_BANK_NV, `FSW_OP_PPB, `FSW_OP_PPB4,
                `FSW_OP_ASP_PROG, `FSW_OP_PPB_LOCK, `FSW_OP_PASSWORD,
                `FSW_OP_GANG_LOCK, `FSW_OP_GANG_UNLOCK: op_class = `FSW_CLASS_REG;
                default: op_class = `FSW_CLASS_NONE;
            endcase
        end
    endfunction

    function allowed_busy;
        input [7:0] op;
        begin
            case (op)
                `FSW_OP_RDSR, `FSW_OP_RDFR, `FSW_OP_RST_EN, `FSW_OP_RST,
                `FSW_OP_SUSPEND: allowed_busy = 1'b1;
                default: allowed_busy = 1'b0;
            endcase
        end
    endfunction

    function is_chip_erase;
        input [7:0] op;
        begin
            is_chip_erase = (op == `FSW_OP_CE_A) || (op == `FSW_OP_CE_B);
        end
    endfunction

    // ****************************************************************
    // Pin synchronisation and edge detection
    // ****************************************************************
    wire [3:0] pins_s;
    wire cs_n_s;
    wire sclk_s;
    wire si_s;
    wire wp_n_s;
    reg sclk_d_q;
    reg cs_n_d_q;

    pin_sync #(
        .WIDTH(4),
        .RESET_VAL(4'b1001)
    ) u_pin_sync (
        .clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .async_i({cs_n_i, sclk_i, si_i, wp_n_i}),
        .sync_o(pins_s)
    );

    assign cs_n_s = pins_s[3];
    assign sclk_s = pins_s[2];
    assign si_s = pins_s[1];
    assign wp_n_s = pins_s[0];

    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            sclk_d_q <= 1'b0;
            cs_n_d_q <= 1'b1;
        end else begin
            sclk_d_q <= sclk_s;
            cs_n_d_q <= cs_n_s;
        end
    end

    wire sclk_rise = sclk_s & ~sclk_d_q & ~cs_n_s;
    wire sclk_fall = ~sclk_s & sclk_d_q & ~cs_n_s;
    wire cs_rise = cs_n_s & ~cs_n_d_q;

    // ****************************************************************
    // State
    // ****************************************************************
    reg [5:0] bit_cnt_q;
    reg [7:0] op_sh_q;
    reg [7:0] data_sh_q;
    reg [7:0] out_sh_q;
    reg [2:0] out_bits_q;
    reg rd_active_q;
    reg rd_func_q;
    reg write_enable_latch_q;
    reg [5:0] nv_bits_q;
    reg [5:0] nv_pend_q;
    reg nv_pend_valid_q;
    reg clear_wel_q;
    reg prog_erase_q;
    reg suspended_q;
    reg rst_armed_q;
    wire tmr_busy;
    wire tmr_done;

    wire busy_flag = tmr_busy & ~suspended_q;
    wire [7:0] status_now = {nv_bits_q, write_enable_latch_q, busy_flag};
    wire [3:0] bp_now = nv_bits_q[`FSW_BIT_BP_HI-2:`FSW_BIT_BP_LO-2];
    wire lock_now = nv_bits_q[`FSW_BIT_LOCK-2];
    wire [7:0] read_value = rd_func_q ? `FSW_FUNC_READ_VALUE : status_now;
    wire [7:0] op_next = {op_sh_q[6:0], si_s};

    // ****************************************************************
    // Instruction admission
    // ****************************************************************
    wire [7:0] cmd = op_sh_q;
    wire cmd_full = cs_rise && (bit_cnt_q >= 6'd8);
    wire busy_gate = ~busy_flag | allowed_busy(cmd);
    wire latch_ok = ~latch_needed(cmd) | write_enable_latch_q;
    wire exec_ok = cmd_full & busy_gate & latch_ok & ~suspended_q;
    wire [1:0] cls = op_class(cmd);
    // A locked status word with the protect pin low drops the status write.
    wire stwr_block = (cmd == `FSW_OP_STWR) &&
                      ((lock_now & ~wp_n_s) || (bit_cnt_q < 6'd16));
    wire ce_block = is_chip_erase(cmd) && (bp_now != 4'h0);
    wire start_timed = exec_ok && (cls != `FSW_CLASS_NONE) && !stwr_block &&
                       !ce_block && !tmr_busy;
    wire vol_skip = cmd == `FSW_OP_VOL_READ_PARAMS || cmd == `FSW_OP_VOL_BANK_WRITE;
    wire accept_plain = exec_ok && (cls == `FSW_CLASS_NONE) && (latch_needed(cmd) | vol_skip);
    wire do_suspend = cmd_full && (cmd == `FSW_OP_SUSPEND) && tmr_busy &&
                      prog_erase_q && !suspended_q;
    wire do_resume = cmd_full && (cmd == `FSW_OP_RESUME) && suspended_q;
    wire do_reset = cmd_full && (cmd == `FSW_OP_RST) && rst_armed_q;
    reg [23:0] tmr_len;

    always @* begin
        tmr_len = REG_WRITE_CYCLES;
        case (cls)
            `FSW_CLASS_PROG: tmr_len = PROG_CYCLES;
            `FSW_CLASS_ERASE: tmr_len = is_chip_erase(cmd) ? CHIP_ERASE_CYCLES : ERASE_CYCLES;
            default: tmr_len = REG_WRITE_CYCLES;
        endcase
    end

    op_busy_timer #(
        .CW(24)
    ) u_op_busy_timer (
        .clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .start_i(start_timed),
        .len_i(tmr_len),
        .hold_i(suspended_q),
        .abort_i(do_reset),
        .busy_o(tmr_busy),
        .done_o(tmr_done)
    );

    // ****************************************************************
    // Serial shifting and register read-out
    // ****************************************************************
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            bit_cnt_q <= 6'h00;
            op_sh_q <= 8'h00;
            data_sh_q <= 8'h00;
            out_sh_q <= 8'h00;
            out_bits_q <= 3'd0;
            rd_active_q <= 1'b0;
            rd_func_q <= 1'b0;
            so_o <= 1'b0;
            so_oe_n_o <= 1'b1;
        end else if (cs_n_s) begin
            bit_cnt_q <= 6'h00;
            rd_active_q <= 1'b0;
            so_oe_n_o <= 1'b1;
        end else begin
            if (sclk_rise) begin
                if (bit_cnt_q < 6'd8) begin
                    op_sh_q <= op_next;
                end else if (bit_cnt_q < 6'd16) begin
                    data_sh_q <= {data_sh_q[6:0], si_s};
                end
                if (bit_cnt_q != `FSW_CNT_SAT) begin
                    bit_cnt_q <= bit_cnt_q + 6'd1;
                end
                if (bit_cnt_q == 6'd7 &&
                    (op_next == `FSW_OP_RDSR || op_next == `FSW_OP_RDFR)) begin
                    rd_active_q <= 1'b1;
                    rd_func_q <= (op_next == `FSW_OP_RDFR);
                    out_bits_q <= 3'd0;
                    out_sh_q <= (op_next == `FSW_OP_RDFR) ? `FSW_FUNC_READ_VALUE
                                                          : status_now;
                end
            end
            if (sclk_fall && rd_active_q) begin
                so_o <= out_sh_q[7];
                so_oe_n_o <= 1'b0;
                out_bits_q <= out_bits_q + 3'd1;
                // Each byte boundary reloads the live value, so polling shows busy ending.
                if (out_bits_q == 3'd7) begin
                    out_sh_q <= read_value;
                end else begin
                    out_sh_q <= {out_sh_q[6:0], 1'b0};
                end
            end
        end
    end

    // ****************************************************************
    // Status word, latch and operation control
    // ****************************************************************
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            write_enable_latch_q <= 1'b0;
            nv_bits_q <= `FSW_NV_RESET;
            nv_pend_q <= `FSW_NV_RESET;
            nv_pend_valid_q <= 1'b0;
            clear_wel_q <= 1'b0;
            prog_erase_q <= 1'b0;
            suspended_q <= 1'b0;
            rst_armed_q <= 1'b0;
        end else begin
            if (cmd_full) begin
                rst_armed_q <= (cmd == `FSW_OP_RST_EN);
            end
            if (do_reset) begin
                write_enable_latch_q <= 1'b0;
                nv_pend_valid_q <= 1'b0;
                suspended_q <= 1'b0;
                prog_erase_q <= 1'b0;
            end else if (tmr_done) begin
                // Completion clears busy whether or not the operation succeeded.
                if (nv_pend_valid_q) begin
                    nv_bits_q <= nv_pend_q;
                end
                nv_pend_valid_q <= 1'b0;
                prog_erase_q <= 1'b0;
                if (clear_wel_q) begin
                    write_enable_latch_q <= 1'b0;
                end
            end else if (start_timed) begin
                // The status write keeps the latch bit out of the written field.
                nv_pend_q <= data_sh_q[7:2];
                nv_pend_valid_q <= (cmd == `FSW_OP_STWR);
                clear_wel_q <= (cmd != `FSW_OP_GANG_LOCK) &&
                               (cmd != `FSW_OP_GANG_UNLOCK);
                prog_erase_q <= (cls == `FSW_CLASS_PROG) || (cls == `FSW_CLASS_ERASE);
            end else if (do_suspend) begin
                suspended_q <= 1'b1;
            end else if (do_resume) begin
                suspended_q <= 1'b0;
            end else if (exec_ok && cmd == `FSW_OP_WSET && bit_cnt_q == 6'd8) begin
                write_enable_latch_q <= 1'b1;
            end else if (exec_ok && cmd == `FSW_OP_WCLR && bit_cnt_q == 6'd8) begin
                write_enable_latch_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            status_word_o <= `FSW_STATUS_RESET;
            quad_lines_enable_o <= 1'b0;
            block_protect_o <= 4'h0;
            op_start_o <= 1'b0;
            op_code_o <= 8'h00;
            op_done_o <= 1'b0;
        end else begin
            status_word_o <= status_now;
            quad_lines_enable_o <= nv_bits_q[`FSW_BIT_QUAD-2];
            block_protect_o <= bp_now;
            op_start_o <= start_timed | accept_plain;
            op_done_o <= tmr_done;
            if (start_timed | accept_plain) begin
                op_code_o <= cmd;
            end
        end
    end

endmodule // flash_status_write_latch

// >>> tb/flash_status_props.sv
/* Checker for the status word block, bound to its top module.
   Assumes it sees the top module's ports only. */
`timescale 1ns/10ps
module flash_status_props (
    // Clock and reset
    input wire core_clk_i,
    input wire rstn_i,
    // Pins and status
    input wire cs_n_i,
    input wire so_oe_n_o,
    input wire [7:0] status_word_o,
    input wire quad_lines_enable_o,
    input wire [3:0] block_protect_o,
    input wire op_start_o,
    input wire [7:0] op_code_o,
    input wire op_done_o
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    wire latch_free = op_code_o inside {8'h75, 8'h7A, 8'hC0, 8'h17};
    wire gang = op_code_o inside {8'h7E, 8'h98};
    logic [2:0] since_start_q;
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || op_start_o) since_start_q <= 3'h0;
        else if (since_start_q != 3'h7) since_start_q <= since_start_q + 3'h1;
    end
    chk_start_needs_wel: assert property (op_start_o && !latch_free |-> status_word_o[1])
        else $error("gated op started with latch clear");
    chk_busy_refuses: assert property (op_start_o && status_word_o[0]
        && $past(status_word_o[0], 2) |-> op_code_o == 8'h75)
        else $error("op started while busy");
    chk_busy_falls_done: assert property ($fell(status_word_o[0]) |-> op_done_o)
        else $error("busy fell without completion");
    chk_done_clears_busy: assert property (op_done_o |-> ##[1:2] !status_word_o[0])
        else $error("busy not cleared after completion");
    chk_done_clears_wel: assert property (op_done_o && !gang |-> ##[1:2] !status_word_o[1])
        else $error("latch not cleared after completion");
    // The busy view must rise within five cycles after a start pulse, or at most three cycles before one.
    chk_busy_rise_start: assert property ($rose(status_word_o[0])
        |-> (since_start_q < 3'h5) or (##[0:3] op_start_o))
        else $error("busy rose without a start");
    chk_bp_mirror: assert property ($stable(status_word_o) [*3]
        |-> block_protect_o == status_word_o[5:2] && quad_lines_enable_o == status_word_o[6])
        else $error("protect or quad view differs from status");
    chk_oe_idle: assert property (cs_n_i [*8] |-> so_oe_n_o)
        else $error("output driven outside a frame");
    cov_start: cover property (op_start_o);
    cov_done: cover property (op_done_o);
    cov_read: cover property (!so_oe_n_o);
endmodule // flash_status_props
bind flash_status_write_latch flash_status_props u_flash_status_props (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i), .so_oe_n_o(so_oe_n_o),
    .status_word_o(status_word_o), .quad_lines_enable_o(quad_lines_enable_o),
    .block_protect_o(block_protect_o), .op_start_o(op_start_o), .op_code_o(op_code_o),
    .op_done_o(op_done_o));

// >>> tb/spi_host_model.sv
/* Host serial controller model issuing one instruction per frame.
   Assumes mode 0 and a 125 ns serial clock that stands low outside frames. */
`timescale 1ns/10ps
module spi_host_model (
    // Serial pins
    output logic cs_n_o,
    output logic sclk_o,
    output logic si_o,
    input wire so_i
);
    // ************************************************************
    // Frame engine
    // ************************************************************
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
    end
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        #2 cs_n_o = 1'b0;
        #62.5;
        for (int i = 0; i < nbits; i++) begin
            si_o = tx[15 - (i % 16)];
            #62.5 sclk_o = 1'b1;
            rx = {rx[14:0], so_i};
            #62.5 sclk_o = 1'b0;
        end
        #62.5 cs_n_o = 1'b1;
        // Idle data is not held, so a design that samples it late sees garbage.
        si_o = ~si_o;
        #500;
    endtask
endmodule // spi_host_model

// >>> tb/tb.sv
/* Self-checking bench for the status word block.
   Assumes the host model and checker are compiled before it. */
`timescale 1ns/10ps
module tb;
    // ************************************************************
    // Wiring and helpers
    // ************************************************************
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic wp_n_i = 1'b1;
    wire cs_n, sclk, si, so, so_oe_n, q_en, op_start, op_done;
    wire [7:0] sw, op_code;
    wire [3:0] bp;
    int fail_count = 0;
    int samples_checked = 0;
    int starts = 0;
    int s0;
    logic [15:0] rx;
    logic [7:0] ops [38] = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E, 8'hD7, 8'h20, 8'h21,
        8'h52, 8'h5C, 8'hD8, 8'hDC, 8'hC7, 8'h60, 8'h42, 8'h65, 8'h63, 8'h85, 8'h83, 8'h64,
        8'h62, 8'h15, 8'h18, 8'hC5, 8'hFB, 8'hE1, 8'hFD, 8'hE3, 8'hE4, 8'h2F, 8'hA6, 8'h91,
        8'h7E, 8'h98, 8'hE8, 8'h43, 8'h4A};
    initial forever #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) if (op_start === 1'b1) starts <= starts + 1;
    flash_status_write_latch #(.PROG_CYCLES(24'h00_0020), .ERASE_CYCLES(24'h00_0028),
        .CHIP_ERASE_CYCLES(24'h00_0030), .REG_WRITE_CYCLES(24'h00_0300))
        u_flash_status_write_latch (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n),
        .sclk_i(sclk), .si_i(si), .wp_n_i(wp_n_i), .so_o(so), .so_oe_n_o(so_oe_n),
        .status_word_o(sw), .quad_lines_enable_o(q_en), .block_protect_o(bp),
        .op_start_o(op_start), .op_code_o(op_code), .op_done_o(op_done));
    spi_host_model u_spi_host_model (.cs_n_o(cs_n), .sclk_o(sclk), .si_o(si),
        .so_i(so_oe_n ? ~so : so));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        @(posedge core_clk_i);
        while (sw[0] !== 1'b0 && n < 3000) begin
            @(posedge core_clk_i);
            n++;
        end
        if (n == 3000) fail_count++;
        repeat (4) @(posedge core_clk_i);
    endtask
    task automatic wr(input logic [7:0] op, input logic [7:0] dat, input int n);
        u_spi_host_model.xfer({op, dat}, n, rx);
        wait_idle();
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        u_spi_host_model.xfer(16'h0500, 24, rx);
        check(rx, 16'h0000);
        check({8'h00, sw}, 16'h0000);
        $display("reset test done");
    endtask
    task automatic t_latch();
        s0 = starts;
        wr(8'h02, 8'h00, 16);
        check(16'(starts - s0), 16'h0000);
        wr(8'h06, 8'h00, 8);
        check({8'h00, sw}, 16'h0002);
        wr(8'h04, 8'h00, 8);
        check({8'h00, sw}, 16'h0000);
        $display("latch test done");
    endtask
    task automatic t_status_write();
        wr(8'h06, 8'h00, 8);
        s0 = starts;
        u_spi_host_model.xfer(16'h017E, 16, rx);
        u_spi_host_model.xfer(16'h0500, 24, rx);
        check(rx, 16'h0303);
        u_spi_host_model.xfer(16'h0200, 16, rx);
        wait_idle();
        check(16'(starts - s0), 16'h0001);
        check({8'h00, sw}, 16'h007C);
        check({11'h000, bp, q_en}, 16'h001F);
        $display("status write test done");
    endtask
    task automatic t_erase_guard();
        wr(8'h06, 8'h00, 8);
        s0 = starts;
        wr(8'hC7, 8'h00, 16);
        wr(8'h60, 8'h00, 16);
        check(16'(starts - s0), 16'h0000);
        check({8'h00, sw}, 16'h007E);
        wr(8'h01, 8'h00, 16);
        check({8'h00, sw}, 16'h0000);
        $display("erase guard test done");
    endtask
    task automatic t_lockout();
        wr(8'h06, 8'h00, 8);
        wr(8'h01, 8'h80, 16);
        @(posedge core_clk_i) wp_n_i <= 1'b0;
        wr(8'h06, 8'h00, 8);
        wr(8'h01, 8'h00, 16);
        check({8'h00, sw}, 16'h0082);
        @(posedge core_clk_i) wp_n_i <= 1'b1;
        wr(8'h01, 8'h00, 16);
        check({8'h00, sw}, 16'h0000);
        $display("lockout test done");
    endtask
    task automatic t_gated();
        foreach (ops[i]) begin
            s0 = starts;
            wr(ops[i], 8'h00, 16);
            wr(8'h06, 8'h00, 8);
            wr(ops[i], 8'h00, 16);
            check(16'(starts - s0), 16'h0001);
            check({8'h00, op_code}, {8'h00, ops[i]});
            wr(8'h04, 8'h00, 8);
        end
        s0 = starts;
        wr(8'hC0, 8'h00, 16);
        wr(8'h17, 8'h00, 16);
        check(16'(starts - s0), 16'h0002);
        $display("gated set test done");
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        t_reset();
        t_latch();
        t_status_write();
        t_erase_guard();
        t_lockout();
        t_gated();
        complete_run();
    end
    initial begin
        #900_000;
        fail_count++;
        complete_run();
    end
endmodule // tb
